//--- shared/tcc_pkg.sv
package tcc_pkg;
  // ------------------------------------------------------------
  // Register byte offsets, one 32-bit word each
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [1:0][7:0] OFS_CAP_HI = {8'h14, 8'h0c};
  localparam logic [1:0][7:0] OFS_CAP_LO = {8'h18, 8'h10};
  localparam logic [1:0][7:0] OFS_CMP_HI = {8'h24, 8'h1c};
  localparam logic [1:0][7:0] OFS_CMP_LO = {8'h28, 8'h20};
  localparam logic [7:0] OFS_CNT_HI  = 8'h2c;
  localparam logic [7:0] OFS_CNT_LO  = 8'h30;
  localparam logic [7:0] OFS_ACNT_HI = 8'h34;
  localparam logic [7:0] OFS_ACNT_LO = 8'h38;

  // ------------------------------------------------------------
  // Control 1 fields
  // ------------------------------------------------------------
  localparam int C1_CAP_IE   = 7;
  localparam int C1_CMP_IE   = 6;
  localparam int C1_OVF_IE   = 5;
  localparam int C1_FORCE2   = 4;
  localparam int C1_FORCE1   = 3;
  localparam int C1_LEVEL2   = 2;
  localparam int C1_CAP1_EDG = 1;
  localparam int C1_LEVEL1   = 0;
  // Force bits are write-only strobes
  localparam logic [7:0] C1_STORE_MASK = 8'he7;

  // ------------------------------------------------------------
  // Control 2 fields
  // ------------------------------------------------------------
  localparam int C2_OUT1_EN  = 7;
  localparam int C2_OUT2_EN  = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM      = 4;
  localparam int C2_CLK_HI   = 3;
  localparam int C2_CLK_LO   = 2;
  localparam int C2_CAP2_EDG = 1;
  localparam int C2_EXT_EDG  = 0;

  // ------------------------------------------------------------
  // Clock select codes, reset values, counter top and one-pulse capture value
  // ------------------------------------------------------------
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;
  localparam logic [15:0] CNT_RELOAD  = 16'hfffc;
  localparam logic [15:0] CNT_TOP     = 16'hffff;
  localparam logic [15:0] OPM_CAP_VAL = 16'hfffd;
  localparam logic [15:0] CMP_RESET   = 16'h8000;
endpackage

//--- design/tcc_timer.sv
// Our own choices: the placing of the registers and register access over APB.
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_in_1,
  input  wire logic        capture_in_2,
  input  wire logic        ext_clock_in,
  input  wire logic        cpu_irq_mask,
  output logic             compare_out_1,
  output logic             compare_out_1_oe,
  output logic             compare_out_2,
  output logic             compare_out_2_oe,
  output logic             timer_irq
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       ctrl1;
    logic [7:0]       ctrl2;
    logic [2:0]       pre;
    logic             ext_prev;
    logic [15:0]      cnt;
    logic             cnt_upd;
    logic [1:0]       cap_prev;
    logic [1:0][15:0] cap;
    logic [1:0][15:0] cmp;
    logic [1:0]       cap_lock;
    logic [1:0]       cmp_inh;
    logic [1:0]       icf;
    logic [1:0]       ocf;
    logic             overflow_flag;
    logic [1:0]       icf_arm;
    logic [1:0]       ocf_arm;
    logic             tof_arm;
    logic [1:0]       pin;
    logic             irq;
    logic [31:0]      rdata;
    logic             err;
  } tcc_state_t;

  tcc_state_t s_r;
  tcc_state_t s_nxt;

  logic       acc;
  logic       rd;
  logic       wr;
  logic       one_pulse;
  logic       pwm_on;
  logic       tick;
  logic [1:0] cap_in;
  logic [1:0] cap_edge;
  logic [1:0] match;
  logic       trig;

  // Offset is a mapped register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= OFS_ACNT_LO) && (a[1:0] == 2'h0);
  endfunction

  // ------------------------------------------------------------
  // Decoded events
  // ------------------------------------------------------------
  assign acc       = psel && penable;
  assign rd        = acc && !pwrite;
  assign wr        = acc && pwrite;
  assign pwm_on    = s_r.ctrl2[C2_PWM];
  assign one_pulse = s_r.ctrl2[C2_ONE_PULSE] && !pwm_on;
  assign cap_in    = {capture_in_2, capture_in_1};
  assign cap_edge[0] = (cap_in[0] != s_r.cap_prev[0]) &&
                       (cap_in[0] == s_r.ctrl1[C1_CAP1_EDG]);
  assign cap_edge[1] = (cap_in[1] != s_r.cap_prev[1]) &&
                       (cap_in[1] == s_r.ctrl2[C2_CAP2_EDG]);
  assign trig      = one_pulse && cap_edge[0];
  // Match seen in first cycle of the equal count
  assign match[0]  = s_r.cnt_upd && (s_r.cnt == s_r.cmp[0]) &&
                     !s_r.cmp_inh[0];
  assign match[1]  = s_r.cnt_upd && (s_r.cnt == s_r.cmp[1]) &&
                     !s_r.cmp_inh[1];

  // Prescaler and external edge give one tick per count
  always_comb begin
    case (s_r.ctrl2[C2_CLK_HI:C2_CLK_LO])
      CLK_DIV2: tick = s_r.pre[0];
      CLK_DIV4: tick = &s_r.pre[1:0];
      CLK_DIV8: tick = &s_r.pre;
      // External edge, no metastability filter needed
      default:  tick = (ext_clock_in != s_r.ext_prev) &&
                       (ext_clock_in == s_r.ctrl2[C2_EXT_EDG]);
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.pre      = s_r.pre + 3'h1;
    s_nxt.ext_prev = ext_clock_in;
    s_nxt.cap_prev = cap_in;
    s_nxt.cnt_upd  = tick;
    if (tick) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end

    // Read data captured in setup so it is ready in access
    if (psel && !penable) begin
      s_nxt.err   = !mapped(paddr);
      s_nxt.rdata = 32'h0000_0000;
      if (paddr == OFS_CTRL1) begin
        s_nxt.rdata[7:0] = s_r.ctrl1;
      end else if (paddr == OFS_CTRL2) begin
        s_nxt.rdata[7:0] = s_r.ctrl2;
      end else if (paddr == OFS_STAT) begin
        s_nxt.rdata[7:0] = {s_r.icf[0], s_r.ocf[0], s_r.overflow_flag,
                            s_r.icf[1], s_r.ocf[1], 3'h0};
      end else if (paddr == OFS_CNT_HI || paddr == OFS_ACNT_HI) begin
        s_nxt.rdata[7:0] = s_r.cnt[15:8];
      end else if (paddr == OFS_CNT_LO || paddr == OFS_ACNT_LO) begin
        s_nxt.rdata[7:0] = s_r.cnt[7:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (paddr == OFS_CAP_HI[i]) begin
          s_nxt.rdata[7:0] = s_r.cap[i][15:8];
        end else if (paddr == OFS_CAP_LO[i]) begin
          s_nxt.rdata[7:0] = s_r.cap[i][7:0];
        end else if (paddr == OFS_CMP_HI[i]) begin
          s_nxt.rdata[7:0] = s_r.cmp[i][15:8];
        end else if (paddr == OFS_CMP_LO[i]) begin
          s_nxt.rdata[7:0] = s_r.cmp[i][7:0];
        end
      end
    end

    // Software side effects, clears first so hardware sets win
    if (acc) begin
      if (rd && paddr == OFS_STAT) begin
        s_nxt.icf_arm = s_r.icf_arm | s_r.icf;
        s_nxt.ocf_arm = s_r.ocf_arm | s_r.ocf;
        s_nxt.tof_arm = s_r.tof_arm | s_r.overflow_flag;
      end else if (wr && paddr == OFS_CTRL1) begin
        s_nxt.ctrl1 = pwdata[7:0] & C1_STORE_MASK;
        if (!s_r.ctrl2[C2_ONE_PULSE] && !pwm_on) begin
          if (pwdata[C1_FORCE1]) begin
            s_nxt.pin[0] = pwdata[C1_LEVEL1];
          end
          if (pwdata[C1_FORCE2]) begin
            s_nxt.pin[1] = pwdata[C1_LEVEL2];
          end
        end
      end else if (wr && paddr == OFS_CTRL2) begin
        s_nxt.ctrl2 = pwdata[7:0];
      end else if (paddr == OFS_CNT_LO || paddr == OFS_ACNT_LO) begin
        if (wr) begin
          s_nxt.cnt = CNT_RELOAD;
        end
        // Alternate low byte leaves the overflow flag alone
        if (paddr == OFS_CNT_LO && s_r.tof_arm) begin
          s_nxt.overflow_flag     = 1'b0;
          s_nxt.tof_arm = 1'b0;
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (rd && paddr == OFS_CAP_HI[i]) begin
          s_nxt.cap_lock[i] = 1'b1;
        end
        if (paddr == OFS_CAP_LO[i]) begin
          s_nxt.cap_lock[i] = 1'b0;
          if (s_r.icf_arm[i]) begin
            s_nxt.icf[i]     = 1'b0;
            s_nxt.icf_arm[i] = 1'b0;
          end
        end
        if (wr && paddr == OFS_CMP_HI[i]) begin
          s_nxt.cmp[i][15:8] = pwdata[7:0];
          s_nxt.cmp_inh[i]   = 1'b1;
        end
        if (paddr == OFS_CMP_LO[i]) begin
          if (wr) begin
            s_nxt.cmp[i][7:0] = pwdata[7:0];
            s_nxt.cmp_inh[i]  = 1'b0;
          end
          if (s_r.ocf_arm[i]) begin
            s_nxt.ocf[i]     = 1'b0;
            s_nxt.ocf_arm[i] = 1'b0;
          end
        end
      end
    end

    // Overflow from FFFFh to 0000h
    if (tick && s_r.cnt == CNT_TOP) begin
      s_nxt.overflow_flag = 1'b1;
    end

    // Compare actions; none while PWM is on
    for (int i = 0; i < 2; i++) begin
      if (match[i] && !pwm_on) begin
        if (one_pulse && i == 0) begin
          s_nxt.pin[0] = s_r.ctrl1[C1_LEVEL1];
        end else if (one_pulse) begin
          // Channel 2 flags a timeout only
          s_nxt.ocf[1] = 1'b1;
        end else begin
          s_nxt.ocf[i] = 1'b1;
          if (s_r.ctrl2[i == 0 ? C2_OUT1_EN : C2_OUT2_EN]) begin
            s_nxt.pin[i] = s_r.ctrl1[i == 0 ? C1_LEVEL1 : C1_LEVEL2];
          end
        end
      end
    end

    // Captures; channel 1 is the trigger in one-pulse mode
    for (int i = 0; i < 2; i++) begin
      // Channel 1 capture only in normal mode
      if (cap_edge[i] && !s_r.cap_lock[i] &&
          (i == 1 || (!s_r.ctrl2[C2_ONE_PULSE] && !pwm_on))) begin
        s_nxt.icf[i] = 1'b1;
        s_nxt.cap[i] = s_r.cnt;
      end
    end
    if (trig) begin
      s_nxt.cnt    = CNT_RELOAD;
      s_nxt.cnt_upd = 1'b0;
      s_nxt.pin[0] = s_r.ctrl1[C1_LEVEL2];
      if (!s_r.cap_lock[0]) begin
        s_nxt.icf[0] = 1'b1;
        s_nxt.cap[0] = OPM_CAP_VAL;
      end
    end

    // Pending flags gated by enable and mask
    s_nxt.irq = !cpu_irq_mask &&
                ((s_r.ctrl1[C1_CAP_IE] && |s_r.icf) ||
                 (s_r.ctrl1[C1_CMP_IE] && |s_r.ocf) ||
                 (s_r.ctrl1[C1_OVF_IE] && s_r.overflow_flag));
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r         <= '0;
      s_r.cnt     <= CNT_RELOAD;
      s_r.cmp     <= {CMP_RESET, CMP_RESET};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero wait states: data was fetched in setup
  assign pready           = 1'b1;
  assign prdata           = s_r.rdata;
  assign pslverr          = s_r.err;
  assign compare_out_1    = s_r.pin[0];
  assign compare_out_2    = s_r.pin[1];
  assign compare_out_1_oe = s_r.ctrl2[C2_OUT1_EN];
  assign compare_out_2_oe = s_r.ctrl2[C2_OUT2_EN] && !one_pulse;
  assign timer_irq        = s_r.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence opm_trigger;
    trig && !s_r.cap_lock[0];
  endsequence
  sequence opm_pulse_end;
    one_pulse && match[0] && !trig;
  endsequence

  cap_load_a: assert property (
    cap_edge[1] && !s_r.cap_lock[1] |=>
      s_r.icf[1] && s_r.cap[1] == $past(s_r.cnt))
    else $error("capture 2 did not latch counter");
  irq_gate_a: assert property (
    s_r.icf[0] && s_r.ctrl1[C1_CAP_IE] && !cpu_irq_mask |=> timer_irq)
    else $error("pending capture did not raise interrupt");
  icf_clear_a: assert property (
    $fell(s_r.icf[0]) |-> $past(s_r.icf_arm[0]) &&
      $past(acc) && $past(paddr) == OFS_CAP_LO[0])
    else $error("capture flag cleared without sequence");
  cap_lock_a: assert property (
    s_r.cap_lock[1] && !acc |=> $stable(s_r.cap[1]))
    else $error("locked capture changed");
  cmp_inh_a: assert property (
    s_r.cmp_inh[1] && !acc |=> !$rose(s_r.ocf[1]))
    else $error("inhibited compare set its flag");
  cmp_match_a: assert property (
    match[1] && !pwm_on |=> s_r.ocf[1])
    else $error("compare match missed flag");
  opm_start_a: assert property (
    opm_trigger |=> s_r.cnt == CNT_RELOAD && s_r.cap[0] == OPM_CAP_VAL &&
      compare_out_1 == $past(s_r.ctrl1[C1_LEVEL2]))
    else $error("one-pulse trigger effects wrong");
  opm_end_a: assert property (
    opm_pulse_end |=> compare_out_1 == $past(s_r.ctrl1[C1_LEVEL1]))
    else $error("pulse did not end on compare 1");
  opm_noflag_a: assert property (
    one_pulse && !$past(acc) |-> !$rose(s_r.ocf[0]))
    else $error("compare flag 1 set in one-pulse mode");
  force_pin_a: assert property (
    wr && paddr == OFS_CTRL1 && pwdata[C1_FORCE1] &&
      !s_r.ctrl2[C2_ONE_PULSE] && !pwm_on && !match[0] |=>
      compare_out_1 == $past(pwdata[C1_LEVEL1]) && $stable(s_r.ocf[0]))
    else $error("force did not copy level");
  cnt_reload_a: assert property (
    wr && paddr == OFS_CNT_LO && !trig |=> s_r.cnt == CNT_RELOAD)
    else $error("counter not reloaded on low write");
endmodule

//--- testbench/tcc_far_end.sv
// ------------------------------------------------------------
// Pins outside the timer: capture sources and timer clock
// ------------------------------------------------------------
module tcc_far_end (
  input  wire logic clock,
  output logic      capture_in_1,
  output logic      capture_in_2,
  output logic      ext_clock_in,
  input  wire logic compare_out_1,
  input  wire logic compare_out_2
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ext_run = 1'b0;
  int   ext_div = 0;

  // Lines idle low until a source drives them
  initial begin
    capture_in_1 = 1'b0;
    capture_in_2 = 1'b0;
    ext_clock_in = 1'b0;
  end

  // Timer clock toggles every 4 cycles; stands still when stopped
  always @(posedge clock) begin
    if (ext_run) begin
      ext_div <= ext_div + 1;
      if (ext_div % 4 == 3)
        ext_clock_in <= ~ext_clock_in;
    end
  end

  // One pulse on a capture line, held long enough to be seen
  task automatic pulse(input int ch);
    @(posedge clock);
    if (ch == 1)
      capture_in_1 <= 1'b1;
    else
      capture_in_2 <= 1'b1;
    repeat (3) @(posedge clock);
    capture_in_1 <= 1'b0;
    capture_in_2 <= 1'b0;
  endtask
endmodule

//--- testbench/tcc_timer_bench.sv
// ------------------------------------------------------------
// Bench for the capture and compare stage
// ------------------------------------------------------------
module tcc_timer_bench
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        cpu_irq_mask = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic        pready, pslverr, last_err, oe1, oe2, timer_irq;
  logic        capture_in_1, capture_in_2, ext_clock_in;
  logic        compare_out_1, compare_out_2;
  logic [31:0] seed = 32'hd8e2;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cmp_m [2] = '{32'h8000, 32'h8000};

  // 250 MHz clock
  always #2 clock = ~clock;

  tcc_timer i_dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .capture_in_1, .capture_in_2,
    .ext_clock_in, .cpu_irq_mask, .compare_out_1,
    .compare_out_1_oe(oe1), .compare_out_2, .compare_out_2_oe(oe2),
    .timer_irq);

  tcc_far_end i_far (.clock, .capture_in_1, .capture_in_2,
    .ext_clock_in, .compare_out_1, .compare_out_2);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic stop_test();
    $display("Errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic fail_wait(input string nm);
    $display("[ERR] %s expected done seen timeout", nm);
    num_errors++;
    stop_test();
  endtask

  // One bus transfer; unused upper write bits carry random noise
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    logic [31:0] r;
    int          n;
    r = rnd();
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {r[23:0], d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      fail_wait("pready");
    rv = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    apb(1'b0, a, 8'h00);
    check(nm, {24'h0, e}, rv);
  endtask

  // Bounded wait for the irq (w=0) or compare pin 1 (w=1)
  task automatic wait_sig(input int w, input logic lv, input int lim,
                          output int n);
    n = 0;
    while ((w ? compare_out_1 : timer_irq) !== lv) begin
      @(posedge clock);
      n++;
      if (n > lim)
        fail_wait("wait_sig");
    end
  endtask

  // Hang guard
  initial begin
    #400000;
    fail_wait("run");
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int          n, d;
    logic [15:0] v;
    logic [1:0]  codes [4];
    codes = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_EXT};
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    check("pins", 32'h0, {compare_out_1, compare_out_2, oe1, oe2});
    for (int i = 0; i < 3; i++)
      rd(8'(i * 4), 8'h00, "ctrl_stat");
    for (int i = 0; i < 2; i++) begin
      rd(OFS_CMP_HI[i], 8'h80, "cmp_hi");
      rd(OFS_CMP_LO[i], 8'h00, "cmp_lo");
    end
    apb(1'b0, 8'h3c, 8'h00);
    check("slverr", 32'h1, last_err);
    // Random compare value read back against the model
    v = 16'(rnd());
    wr(OFS_CMP_HI[0], v[15:8]);
    wr(OFS_CMP_LO[0], v[7:0]);
    cmp_m[0] = v;
    rd(OFS_CMP_HI[0], 8'(cmp_m[0] >> 8), "cmp1_hi");
    rd(OFS_CMP_LO[0], 8'(cmp_m[0]), "cmp1_lo");
    // Each clock source: reload, then time the match at 0000h
    cpu_irq_mask <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      d = (k == 3) ? 8 : (2 << k);
      i_far.ext_run = (k == 3);
      wr(OFS_CTRL2, 8'h81 | {4'h0, codes[k], 2'b00});
      wr(OFS_CTRL1, {7'h20, ~k[0]});
      wr(OFS_CMP_HI[0], 8'h00);
      apb(1'b0, OFS_STAT, 8'h00);
      wr(OFS_CMP_LO[0], 8'h00);
      wr(OFS_CNT_LO, 8'h00);
      wait_sig(0, 1'b1, 60, n);
      check("tick_time", 32'h1, n >= 3 * d && n <= 4 * d + 6);
      check("out1_level", {31'h0, ~k[0]}, compare_out_1);
      rd(OFS_STAT, 8'h60, "cmp_flag");
      wr(OFS_CMP_HI[0], 8'hff);
      wr(OFS_CMP_LO[0], 8'h00);
      rd(OFS_STAT, 8'h20, "cmp_clear");
    end
    i_far.ext_run = 1'b0;
    // Capture 2 while masked, then unmask, then clear
    cpu_irq_mask <= 1'b1;
    wr(OFS_CTRL2, 8'h0a);
    wr(OFS_CTRL1, 8'h80);
    i_far.pulse(2);
    repeat (4) @(posedge clock);
    check("irq_masked", 32'h0, timer_irq);
    rd(OFS_STAT, 8'h30, "cap_flag2");
    cpu_irq_mask <= 1'b0;
    repeat (2) @(posedge clock);
    check("irq_pending", 32'h1, timer_irq);
    rd(OFS_CAP_HI[1], 8'h00, "cap2_hi");
    apb(1'b0, OFS_CAP_LO[1], 8'h00);
    check("cap2_lo", 32'h1, rv[7:0] < 8'h20);
    rd(OFS_STAT, 8'h20, "cap_clear");
    check("irq_clear", 32'h0, timer_irq);
    // High byte read blocks the next capture until low byte read
    apb(1'b0, OFS_CAP_HI[1], 8'h00);
    i_far.pulse(2);
    repeat (4) @(posedge clock);
    rd(OFS_STAT, 8'h20, "cap_locked");
    apb(1'b0, OFS_CAP_LO[1], 8'h00);
    i_far.pulse(2);
    repeat (4) @(posedge clock);
    rd(OFS_STAT, 8'h30, "cap_unlocked");
    apb(1'b0, OFS_CAP_LO[1], 8'h00);
    // Forced level: pin follows, no flag, no request
    wr(OFS_CTRL2, 8'h8c);
    wr(OFS_CTRL1, 8'h49);
    repeat (3) @(posedge clock);
    check("force_pin", 32'h1, compare_out_1);
    check("force_irq", 32'h0, timer_irq);
    rd(OFS_STAT, 8'h20, "force_flag");
    wr(OFS_CTRL1, 8'h08);
    repeat (3) @(posedge clock);
    check("force_low", 32'h0, compare_out_1);
    // Second pin forced high through its own enable
    wr(OFS_CTRL2, 8'hcc);
    wr(OFS_CTRL1, 8'h14);
    repeat (3) @(posedge clock);
    check("force_pin2", 32'h1, compare_out_2);
    check("oe2_on", 32'h1, oe2);
    // One-pulse: trigger on capture 1, end at compare 1 = 0010h
    // Divide by 8 so the counter runs and the pulse is long enough
    wr(OFS_CTRL2, 8'ha8);
    wr(OFS_CMP_HI[0], 8'h00);
    apb(1'b0, OFS_STAT, 8'h00);
    wr(OFS_CMP_LO[0], 8'h10);
    wr(OFS_CTRL1, 8'h06);
    i_far.pulse(1);
    repeat (3) @(posedge clock);
    check("opm_start", 32'h1, compare_out_1);
    check("oe2_opm", 32'h0, oe2);
    wr(OFS_CTRL1, 8'h0e);
    repeat (3) @(posedge clock);
    check("opm_force", 32'h1, compare_out_1);
    rd(OFS_STAT, 8'ha0, "opm_stat");
    rd(OFS_CAP_HI[0], 8'hff, "opm_cap_hi");
    rd(OFS_CAP_LO[0], 8'hfd, "opm_cap_lo");
    wait_sig(1, 1'b0, 200, n);
    check("opm_width", 32'h1, n > 100);
    rd(OFS_STAT, 8'h20, "opm_no_flag1");
    stop_test();
  end
endmodule
